//--- soa_host.sv
`default_nettype none
module soa_host (
   input  wire logic        clk_sys,
   output logic      [7:0]  regAddr,
   output logic      [31:0] regWdata,
   output logic             regWrite,
   output logic             regRead,
   input  wire logic [31:0] regRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idle at time zero
   initial begin
      {regRead, regWrite, regAddr, regWdata} = 42'h0;
   end
   // one-cycle write strobe
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {regWrite, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   // one-cycle read strobe, data taken in the following cycle
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      {regRead, regAddr} <= {1'b1, a};
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      d = regRdata;
   endtask
endmodule
`default_nettype wire

//--- soa_monitor.sv
// The strobed register port and the address map were chosen for this implementation.
`include "soa_monitor_defines.svh"
`default_nettype none
module soa_monitor (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [31:0] regRdata,
   input  wire logic        sampleValid,
   input  wire logic [15:0] supplyInput,
   input  wire logic [15:0] forwardPower,
   input  wire logic [15:0] reflectedPower,
   input  wire logic [15:0] supplyCurrent,
   input  wire logic [15:0] forwardDbm,
   input  wire logic [15:0] reflectedDbm,
   output logic             rfEnable,
   output logic             throttleReflect,
   output logic      [15:0] gainTarget,
   output logic             irq
);
   // ==========================================
   // configuration registers
   soa_monitor_pkg::limit_t curHigh_q, curShut_q, disHigh_q, disShut_q;
   soa_monitor_pkg::limit_t fwdHigh_q, fwdShut_q, rflHigh_q, rflShut_q;
   logic [9:0]  enable_q;
   logic [15:0] grace_q;
   logic        autoGain_q;
   logic        rfRequest_q;
   logic [`ST_WIDTH-1:0] status_q, mask_q;
   logic [`ST_WIDTH-1:0] event_d;
   logic        errClear;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = regWrite && (a == off);
   endfunction

   // strobe read directly so the clear drops with the write strobe
   assign errClear = regWrite && (regAddr == `REG_CTRL) && regWdata[2];

   // ==========================================
   // register writes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         curHigh_q <= `CUR_HIGH_RST;
         curShut_q <= `CUR_SHUT_RST;
         disHigh_q <= `DIS_HIGH_RST;
         disShut_q <= `DIS_SHUT_RST;
         fwdHigh_q <= `FWD_HIGH_RST;
         fwdShut_q <= `FWD_SHUT_RST;
         rflHigh_q <= `RFL_HIGH_RST;
         rflShut_q <= `RFL_SHUT_RST;
         enable_q  <= `ENABLE_RST;
         grace_q   <= `GRACE_RST;
         autoGain_q  <= 1'b0;
         rfRequest_q <= 1'b0;
         mask_q    <= '0;
      end else begin
         if (hit(regAddr, `REG_CTRL)) begin
            rfRequest_q <= regWdata[0];
            autoGain_q  <= regWdata[1];
         end
         if (hit(regAddr, `REG_CUR_LIM)) begin
            curHigh_q <= regWdata[15:0];
            curShut_q <= regWdata[31:16];
         end
         if (hit(regAddr, `REG_DIS_LIM)) begin
            disHigh_q <= regWdata[15:0];
            disShut_q <= regWdata[31:16];
         end
         if (hit(regAddr, `REG_FWD_LIM)) begin
            fwdHigh_q <= regWdata[15:0];
            fwdShut_q <= regWdata[31:16];
         end
         if (hit(regAddr, `REG_RFL_LIM)) begin
            rflHigh_q <= regWdata[15:0];
            rflShut_q <= regWdata[31:16];
         end
         if (hit(regAddr, `REG_GRACE)) grace_q <= regWdata[15:0];
         if (hit(regAddr, `REG_MASK)) mask_q <= regWdata[`ST_WIDTH-1:0];
         // per-type enable write: type in [11:8], value in [0]
         if (hit(regAddr, `REG_ENABLE) && regWdata[11:8] <= 4'h9
             && regWdata[11:8] != 4'(`TYPE_WDOG)) begin
            enable_q[regWdata[11:8]] <= regWdata[0];
         end
      end
   end

   // ==========================================
   // dissipation, saturated to 16 bits
   logic signed [18:0] disSum;
   logic [15:0]        dissipation;
   assign disSum = 19'(supplyInput) - 19'(forwardPower) + 19'(reflectedPower);
   assign dissipation = disSum[18] ? 16'h0000 :
                        (|disSum[17:16]) ? 16'hFFFF : disSum[15:0];

   // ==========================================
   // raw violations; events take them only on a new sample, the throttle every cycle
   logic curHi, curSd, disHi, disSd, fwdHi, fwdSd, rflHi, rflSd;
   assign curHi = enable_q[`TYPE_CUR] && supplyCurrent > curHigh_q;
   assign curSd = enable_q[`TYPE_CUR] && supplyCurrent > curShut_q;
   assign disHi = enable_q[`TYPE_DIS] && dissipation > disHigh_q;
   assign disSd = enable_q[`TYPE_DIS] && dissipation > disShut_q;
   assign fwdHi = enable_q[`TYPE_FWD] && forwardDbm > fwdHigh_q;
   assign fwdSd = enable_q[`TYPE_FWD] && forwardDbm > fwdShut_q;
   assign rflHi = enable_q[`TYPE_RFL] && reflectedDbm > rflHigh_q;
   assign rflSd = enable_q[`TYPE_RFL] && reflectedDbm > rflShut_q;

   // ==========================================
   // grace timers for dissipation and reflection
   logic [3:0] graceIn;
   logic [3:0] graceOk;
   assign graceIn = {rflSd, rflHi, disSd, disHi};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gGrace
         soa_monitor_pkg::grace_state_t st_q;
         logic [17:0] sub_q;
         logic [15:0] ms_q;
         logic        viol_q;
         // holds the last sampled comparison
         always_ff @(posedge clk_sys) begin
            if (rst) viol_q <= 1'b0;
            else if (sampleValid) viol_q <= graceIn[g];
         end
         // counts milliseconds of unbroken violation
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               st_q  <= soa_monitor_pkg::GRACE_IDLE;
               sub_q <= '0;
               ms_q  <= '0;
            end else begin
               case (st_q)
                  soa_monitor_pkg::GRACE_IDLE: begin
                     sub_q <= '0;
                     ms_q  <= '0;
                     if (viol_q) st_q <= soa_monitor_pkg::GRACE_RUN;
                  end
                  soa_monitor_pkg::GRACE_RUN: begin
                     if (!viol_q) begin
                        st_q  <= soa_monitor_pkg::GRACE_IDLE;
                        sub_q <= '0;
                        ms_q  <= '0;
                     end else if (sub_q == 18'(`CYC_PER_MS - 1)) begin
                        sub_q <= '0;
                        if (ms_q != 16'hFFFF) ms_q <= ms_q + 16'h0001;
                     end else begin
                        sub_q <= sub_q + 18'h00001;
                     end
                  end
                  default: st_q <= soa_monitor_pkg::GRACE_IDLE;
               endcase
            end
         end
         // react only once the period is exceeded
         assign graceOk[g] = viol_q && (st_q == soa_monitor_pkg::GRACE_RUN)
                             && (grace_q == 16'h0000 || ms_q >= grace_q);
      end
   endgenerate

   // ==========================================
   // event collection, current and forward act directly
   always_comb begin
      event_d = '0;
      if (sampleValid) begin
         event_d[`ST_CUR_HI] = curHi;
         event_d[`ST_CUR_SD] = curSd;
         event_d[`ST_FWD_HI] = fwdHi;
         event_d[`ST_FWD_SD] = fwdSd;
      end
      event_d[`ST_DIS_HI] = graceOk[0];
      event_d[`ST_DIS_SD] = graceOk[1];
      event_d[`ST_RFL_HI] = graceOk[2];
      event_d[`ST_RFL_SD] = graceOk[3];
   end

   // sticky status, set wins over clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         status_q <= '0;
      end else begin
         logic [`ST_WIDTH-1:0] clr;
         clr = '0;
         if (errClear) clr = '1;
         if (hit(regAddr, `REG_STATUS)) clr = clr | regWdata[`ST_WIDTH-1:0];
         status_q <= (status_q & ~clr) | event_d;
      end
   end

   // ==========================================
   // rf output: killed by any shutdown bit, warnings leave it
   logic shutAny;
   assign shutAny = status_q[`ST_CUR_SD] | status_q[`ST_DIS_SD]
                  | status_q[`ST_FWD_SD] | status_q[`ST_RFL_SD];
   always_ff @(posedge clk_sys) begin
      if (rst) rfEnable <= 1'b0;
      else rfEnable <= rfRequest_q && !shutAny && !(|(event_d & 8'hAA));
   end

   // ==========================================
   // auto gain reflection throttle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         throttleReflect <= 1'b0;
         gainTarget      <= '0;
      end else begin
         throttleReflect <= autoGain_q && rflHi;
         gainTarget      <= (autoGain_q && rflHi) ? rflHigh_q : forwardDbm;
      end
   end

   // interrupt level
   always_ff @(posedge clk_sys) begin
      if (rst) irq <= 1'b0;
      else irq <= |(status_q & mask_q);
   end

   // ==========================================
   // read data, one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         regRdata <= '0;
      end else if (regRead) begin
         case (regAddr)
            `REG_CTRL:    regRdata <= {29'h0, 1'b0, autoGain_q, rfRequest_q};
            `REG_ENABLE:  regRdata <= {22'h0, enable_q};
            `REG_GRACE:   regRdata <= {16'h0, grace_q};
            `REG_CUR_LIM: regRdata <= {curShut_q, curHigh_q};
            `REG_DIS_LIM: regRdata <= {disShut_q, disHigh_q};
            `REG_FWD_LIM: regRdata <= {fwdShut_q, fwdHigh_q};
            `REG_RFL_LIM: regRdata <= {rflShut_q, rflHigh_q};
            `REG_STATUS:  regRdata <= {24'h0, status_q};
            `REG_MASK:    regRdata <= {24'h0, mask_q};
            `REG_ENABLE_ALL: regRdata <= {24'h0, enable_q[7:2], 1'b0, enable_q[0]};
            default:      regRdata <= 32'h0000_0000;
         endcase
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

//--- soa_monitor_defines.svh
// What this block does
// - current above high limit warns; above shutdown limit errors and kills rf
// - current limits default to 5.5 A high and 6 A shutdown, readable
// - dissipation equals supply power minus forward power plus reflected power
// - dissipation above high warns; above shutdown errors and kills rf
// - dissipation protection is off after reset
// - forward power above high warns; above shutdown errors and kills rf
// - forward limits default to 47.40 dBm high and 48.15 dBm shutdown
// - a protection acts only while its enable bit is one
// - protection types are numbered 0 to 9 in fixed order
// - enable writes to type 1 are ignored; watchdog always on
// - the all-enables read covers types 0 to 7 in type order
// - in the all-enables read the type 1 field reads zero
// - reflection and dissipation warn or error only after violation outlasts grace period; the auto gain throttle does not wait
// - reflection above high warns; above shutdown errors and kills rf
// - in auto gain, high reflection makes the loop regulate reflection to the limit
// - a warning sets its status bit while rf stays on
// - status bits stay set until an explicit clear
`ifndef SOA_MONITOR_DEFINES_SVH
`define SOA_MONITOR_DEFINES_SVH
// ==========================================
// register offsets (word index = byte/4)
`define REG_CTRL        8'h00
`define REG_ENABLE      8'h04
`define REG_GRACE       8'h08
`define REG_CUR_LIM     8'h0C
`define REG_DIS_LIM     8'h10
`define REG_FWD_LIM     8'h14
`define REG_RFL_LIM     8'h18
`define REG_STATUS      8'h1C
`define REG_MASK        8'h20
`define REG_ENABLE_ALL  8'h24
// ==========================================
// reset values; current in mA, power in mW, dBm in centi-dBm
`define CUR_HIGH_RST    16'h157C
`define CUR_SHUT_RST    16'h1770
`define FWD_HIGH_RST    16'h1284
`define FWD_SHUT_RST    16'h12CF
`define DIS_HIGH_RST    16'h0000
`define DIS_SHUT_RST    16'h0000
`define RFL_HIGH_RST    16'h1275
`define RFL_SHUT_RST    16'h1284
`define ENABLE_RST      10'h085
`define GRACE_RST       16'h0000
// ==========================================
// timing
`define CLK_MHZ         250
`define MS_NS           1000000
`define CLK_NS          4
`define CYC_PER_MS      (`MS_NS / `CLK_NS)
// ==========================================
// status bit positions
`define ST_CUR_HI   0
`define ST_CUR_SD   1
`define ST_DIS_HI   2
`define ST_DIS_SD   3
`define ST_FWD_HI   4
`define ST_FWD_SD   5
`define ST_RFL_HI   6
`define ST_RFL_SD   7
`define ST_WIDTH    8
// ==========================================
// protection type numbers
`define TYPE_WDOG   1
`define TYPE_RFL    2
`define TYPE_DIS    4
`define TYPE_CUR    7
`define TYPE_FWD    9
`endif

//--- soa_monitor_pkg.sv
`default_nettype none
package soa_monitor_pkg;
   // ==========================================
   // grace timer states
   typedef enum logic [0:0] {
      GRACE_IDLE = 1'b0,
      GRACE_RUN  = 1'b1
   } grace_state_t;
   typedef logic [15:0] limit_t;
endpackage
`default_nettype wire

//--- soa_monitor_sva.sv
`include "soa_monitor_defines.svh"
`default_nettype none
module soa_monitor_sva (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regRdata,
   input wire logic        sampleValid,
   input wire logic [15:0] supplyCurrent,
   input wire logic [15:0] forwardDbm,
   input wire logic [15:0] reflectedDbm,
   input wire logic        rfEnable,
   input wire logic        throttleReflect,
   input wire logic [15:0] gainTarget,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // shadow of host settings
   logic [31:0] curLim_q, fwdLim_q, rflLim_q;
   logic [9:0]  en_q;
   logic [7:0]  mask_q;
   logic [1:0]  ctrl_q;
   logic        graceZero_q;

   // follow register writes except dissipation limits and status
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         curLim_q <= {`CUR_SHUT_RST, `CUR_HIGH_RST};
         fwdLim_q <= {`FWD_SHUT_RST, `FWD_HIGH_RST};
         rflLim_q <= {`RFL_SHUT_RST, `RFL_HIGH_RST};
         en_q <= `ENABLE_RST;
         mask_q <= 8'h00;
         ctrl_q <= 2'h0;
         graceZero_q <= 1'b1;
      end else if (regWrite) begin
         case (regAddr)
            `REG_CTRL: ctrl_q <= regWdata[1:0];
            `REG_GRACE: graceZero_q <= (regWdata[15:0] == 16'h0000);
            `REG_CUR_LIM: curLim_q <= regWdata;
            `REG_FWD_LIM: fwdLim_q <= regWdata;
            `REG_RFL_LIM: rflLim_q <= regWdata;
            `REG_MASK: mask_q <= regWdata[7:0];
            `REG_ENABLE: if (regWdata[11:8] <= 4'h9 && regWdata[11:8] != 4'h1) begin
               en_q[regWdata[11:8]] <= regWdata[0];
            end
            default: ;
         endcase
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ==========================================
   // properties
   property p_rd_idle; !$past(regRead) |-> regRdata == 32'h0; endproperty
   property p_en_all;
      $past(regRead && regAddr == `REG_ENABLE_ALL) |-> regRdata[31:8] == 24'h0 && !regRdata[1];
   endproperty
   property p_cur_shut;
      sampleValid && en_q[7] && supplyCurrent > curLim_q[31:16] |=> !rfEnable;
   endproperty
   property p_fwd_shut;
      sampleValid && en_q[9] && forwardDbm > fwdLim_q[31:16] |=> !rfEnable;
   endproperty
   property p_rfl_shut;
      sampleValid && en_q[2] && graceZero_q && reflectedDbm > rflLim_q[31:16] |-> ##3 !rfEnable;
   endproperty
   property p_rf_req; $rose(rfEnable) |-> ctrl_q[0]; endproperty
   property p_thr_auto; throttleReflect |-> ctrl_q[1] || $past(ctrl_q[1]); endproperty
   property p_thr_target; throttleReflect |-> gainTarget == rflLim_q[15:0]; endproperty
   property p_irq_mask; irq |-> mask_q != 8'h00 || $past(mask_q) != 8'h00; endproperty

   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   a_en_all: assert property (p_en_all) else $error("all-enables read wrong");
   a_cur_shut: assert property (p_cur_shut) else $error("rf on after current shutdown");
   a_fwd_shut: assert property (p_fwd_shut) else $error("rf on after forward shutdown");
   a_rfl_shut: assert property (p_rfl_shut) else $error("rf on after reflect shutdown");
   a_rf_req: assert property (p_rf_req) else $error("rf rose without request");
   a_thr_auto: assert property (p_thr_auto) else $error("throttle outside autogain");
   a_thr_target: assert property (p_thr_target) else $error("throttle target wrong");
   a_irq_mask: assert property (p_irq_mask) else $error("irq while fully masked");

   c_cur_shut: cover property (p_cur_shut);
   c_throttle: cover property (throttleReflect);
   c_irq: cover property ($rose(irq));
endmodule
bind soa_monitor soa_monitor_sva soa_monitor_sva_inst (.clk_sys(clk_sys), .rst(rst),
   .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
   .regRdata(regRdata), .sampleValid(sampleValid), .supplyCurrent(supplyCurrent),
   .forwardDbm(forwardDbm), .reflectedDbm(reflectedDbm), .rfEnable(rfEnable),
   .throttleReflect(throttleReflect), .gainTarget(gainTarget), .irq(irq));
`default_nettype wire

//--- soa_monitor_test.sv
`include "soa_monitor_defines.svh"
`default_nettype none
module soa_monitor_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, rst, regWrite, regRead, sampleValid, rfEnable, throttleReflect, irq;
   logic [7:0]  regAddr, maskV;
   logic [31:0] regWdata, regRdata, rdv;
   logic [15:0] supplyInput, forwardPower, reflectedPower, supplyCurrent, forwardDbm;
   logic [15:0] reflectedDbm, gainTarget;
   int          mismatches, checks;

   soa_monitor soa_monitor_inst (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .sampleValid(sampleValid), .supplyInput(supplyInput), .forwardPower(forwardPower),
      .reflectedPower(reflectedPower), .supplyCurrent(supplyCurrent),
      .forwardDbm(forwardDbm), .reflectedDbm(reflectedDbm), .rfEnable(rfEnable),
      .throttleReflect(throttleReflect), .gainTarget(gainTarget), .irq(irq));
   soa_host soa_host_inst (.clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));

   // ==========================================
   // clock and helpers
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task conclude();
      if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      soa_host_inst.rd(a, rdv);
      cmp(rdv, exp);
   endtask
   // one measurement pulse, values held afterwards
   task smp(input logic [15:0] cur, fdb, rdb, sup, fp, rp);
      @(posedge clk_sys);
      sampleValid <= 1'b1;
      {supplyCurrent, forwardDbm, reflectedDbm, supplyInput, forwardPower, reflectedPower}
         <= {cur, fdb, rdb, sup, fp, rp};
      @(posedge clk_sys);
      sampleValid <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   // event, then quiet sample, status check, clear and restart rf
   task ev(input logic [15:0] cur, fdb, rdb, sup, fp, rp, input logic [7:0] st,
           input logic rf, input logic thr);
      smp(cur, fdb, rdb, sup, fp, rp);
      cmp(32'(rfEnable), 32'(rf));
      if (rf) begin
         cmp(32'(throttleReflect), 32'(thr));
         cmp(32'(gainTarget), 32'(thr ? 16'(`RFL_HIGH_RST) : fdb));
      end
      smp(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      rdc(`REG_STATUS, 32'(st));
      cmp(32'(irq), 32'((st & maskV) != 8'h00));
      soa_host_inst.wr(`REG_STATUS, 32'hFF);
      soa_host_inst.wr(`REG_CTRL, 32'h7);
      repeat (3) @(posedge clk_sys);
      #1;
      rdc(`REG_STATUS, 32'h0);
      cmp(32'({irq, rfEnable}), 32'h1);
   endtask

   // ==========================================
   // watchdog
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      conclude();
   end

   // ==========================================
   // main sequence
   initial begin
      {rst, sampleValid, maskV, mismatches, checks} = {1'b1, 1'b0, 8'hFF, 64'h0};
      {supplyCurrent, forwardDbm, reflectedDbm, supplyInput, forwardPower} = 80'h0;
      reflectedPower = 16'h0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(`REG_CUR_LIM, {`CUR_SHUT_RST, `CUR_HIGH_RST});
      rdc(`REG_FWD_LIM, {`FWD_SHUT_RST, `FWD_HIGH_RST});
      rdc(`REG_ENABLE_ALL, 32'h85);
      rdc(8'hFC, 32'h0);
      soa_host_inst.wr(`REG_MASK, 32'hFF);
      soa_host_inst.wr(`REG_CTRL, 32'h3);
      ev(16'h0, 16'h0, 16'h0, 16'h07D0, 16'h0, 16'h0, 8'h00, 1'b1, 1'b0);
      soa_host_inst.wr(`REG_ENABLE, 32'h101);
      rdc(`REG_ENABLE, 32'h085);
      soa_host_inst.wr(`REG_DIS_LIM, 32'h03E8_01F4);
      for (int t = 0; t < 10; t++) soa_host_inst.wr(`REG_ENABLE, 32'(t << 8) | 32'h1);
      rdc(`REG_ENABLE, 32'h3FD);
      rdc(`REG_ENABLE_ALL, 32'hFD);
      soa_host_inst.wr(`REG_ENABLE, 32'h700);
      ev(16'h1771, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 8'h00, 1'b1, 1'b0);
      soa_host_inst.wr(`REG_ENABLE, 32'h701);
      ev(16'h157D, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 8'h01, 1'b1, 1'b0);
      ev(16'h1771, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 8'h03, 1'b0, 1'b0);
      ev(16'h0, 16'h1285, 16'h0, 16'h0, 16'h0, 16'h0, 8'h10, 1'b1, 1'b0);
      ev(16'h0, 16'h12D0, 16'h0, 16'h0, 16'h0, 16'h0, 8'h30, 1'b0, 1'b0);
      ev(16'h0, 16'h0, 16'h0, 16'h07D0, 16'h05DC, 16'h0064, 8'h04, 1'b1, 1'b0);
      ev(16'h0, 16'h0, 16'h0, 16'h07D0, 16'h03E8, 16'h0064, 8'h0C, 1'b0, 1'b0);
      ev(16'h0, 16'h0, 16'h1276, 16'h0, 16'h0, 16'h0, 8'h40, 1'b1, 1'b1);
      ev(16'h0, 16'h0, 16'h1285, 16'h0, 16'h0, 16'h0, 8'hC0, 1'b0, 1'b1);
      soa_host_inst.wr(`REG_CTRL, 32'h1);
      ev(16'h0, 16'h0, 16'h1276, 16'h0, 16'h0, 16'h0, 8'h40, 1'b1, 1'b0);
      soa_host_inst.wr(`REG_CUR_LIM, 32'h1770_1000);
      ev(16'h1001, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 8'h01, 1'b1, 1'b0);
      maskV = 8'h00;
      soa_host_inst.wr(`REG_MASK, 32'h0);
      ev(16'h1001, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 8'h01, 1'b1, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
